/* File: hdl/serial_config_bitstream_source.sv */
// Serial configuration bitstream source: stored bits shifted out on a serial clock
`timescale 1ns/1ps
module serial_config_bitstream_source #(
  parameter int BIT_COUNT = cfg_loader_pkg::BIT_COUNT_DEF,
  parameter int WORD_W = cfg_loader_pkg::WORD_W_DEF,
  parameter int FIFO_DEPTH = cfg_loader_pkg::FIFO_DEPTH_DEF
) (
  input wire logic i_core_clk,
  input wire logic i_srst,
  input wire logic i_oe,
  input wire logic i_cs_n,
  input wire logic i_dclk,
  output logic o_dclk,
  output logic o_dclk_oe,
  output logic o_target_serial_data_in,
  output logic o_target_serial_data_oe,
  output logic o_cascade_select_out_n,
  input wire logic i_prog_wr,
  input wire logic [$clog2((BIT_COUNT + WORD_W - 1) / WORD_W)-1:0] i_prog_addr,
  input wire logic [WORD_W-1:0] i_prog_data
);

  // Sizes derived from the stored bitstream length, the word width and the oscillator half period
  localparam int WORDS = (BIT_COUNT + WORD_W - 1) / WORD_W;
  localparam int ADDR_W = (BIT_COUNT > 1) ? $clog2(BIT_COUNT) : 1;
  localparam int RD_W = $clog2(WORDS + 1);
  localparam int MA_W = (WORDS > 1) ? $clog2(WORDS) : 1; // Store word address width
  localparam int BL_W = $clog2(WORD_W + 1);
  localparam int DIV_W = $clog2(cfg_loader_pkg::OSC_HALF_CYC + 1);
  localparam logic [ADDR_W-1:0] FINAL = ADDR_W'(BIT_COUNT - 1);
  localparam logic [DIV_W-1:0] HALF_LAST = DIV_W'(cfg_loader_pkg::OSC_HALF_CYC - 1);

  // Nonvolatile store, written only by the programming port
  logic [WORD_W-1:0] mem [WORDS];

  // Registered state
  cfg_loader_pkg::mode_e mode; // Chain position
  logic oe_prev; // Enable level one cycle ago
  logic [ADDR_W-1:0] addr; // Bit address counter
  logic done; // All bits sent
  logic [RD_W-1:0] rd_addr; // Next word to prefetch
  logic [WORD_W-1:0] sh; // Word being serialised
  logic [BL_W-1:0] bits_left; // Bits of sh not yet passed
  logic loaded; // sh holds a valid word
  logic [DIV_W-1:0] div_cnt; // Oscillator divider
  logic dclk_int; // Oscillator output
  logic dclk_prev; // Sampled external clock, last cycle

  // Next values
  cfg_loader_pkg::mode_e next_mode;
  logic [ADDR_W-1:0] next_addr;
  logic next_done;
  logic [RD_W-1:0] next_rd_addr;
  logic [WORD_W-1:0] next_sh;
  logic [BL_W-1:0] next_bits_left;
  logic next_loaded;
  logic [DIV_W-1:0] next_div_cnt;
  logic next_dclk_int;
  logic next_data_oe;
  logic next_casc_n;

  // Decoded strobes
  logic oe_rise; // Enable just released
  logic osc_run; // Oscillator allowed to run
  logic dclk_rise; // Rising serial clock edge
  logic advance; // Counter steps this cycle
  logic word_last; // Current bit is the word's last

  // Prefetch buffer handshakes
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [WORD_W-1:0] fifo_out_data;

  // Programming port fills the store; contents survive any reset
  always_ff @(posedge i_core_clk) begin
    if (i_prog_wr) begin
      mem[i_prog_addr] <= i_prog_data;
    end
  end

  // Prefetch buffer: a slow serial clock stalls the reader once it fills
  cfg_stream_fifo #(
    .WIDTH(WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_prefetch (
    .i_core_clk(i_core_clk),
    .i_srst(i_srst),
    .i_flush(!i_oe),
    .i_in_valid(fifo_in_valid),
    .o_in_ready(fifo_in_ready),
    .i_in_data(mem[(rd_addr < RD_W'(WORDS)) ? rd_addr[MA_W-1:0] : '0]),
    .o_out_valid(fifo_out_valid),
    .i_out_ready(fifo_out_ready),
    .o_out_data(fifo_out_data)
  );

  // Edge detection and enables
  always_comb begin
    oe_rise = i_oe && !oe_prev;
    // The oscillator also waits for a loaded word so a bit is always ready
    osc_run = (mode == cfg_loader_pkg::MODE_FIRST) && i_oe && !i_cs_n && !done && loaded;
    if (mode == cfg_loader_pkg::MODE_FIRST) begin
      dclk_rise = osc_run && (div_cnt == HALF_LAST) && !dclk_int;
    end else begin
      // Edge taken from the pin sampled on the core clock
      dclk_rise = i_dclk && !dclk_prev;
    end
    advance = dclk_rise && i_oe && !i_cs_n && !done && loaded;
    word_last = (bits_left == BL_W'(1));
    fifo_in_valid = i_oe && (rd_addr < RD_W'(WORDS));
    fifo_out_ready = i_oe && (!loaded || (advance && word_last));
  end

  // Next-state computation
  always_comb begin
    next_mode = mode;
    next_addr = addr;
    next_done = done;
    next_rd_addr = rd_addr;
    next_sh = sh;
    next_bits_left = bits_left;
    next_loaded = loaded;
    next_div_cnt = div_cnt;
    next_dclk_int = dclk_int;
    if (oe_rise) begin
      // Chain position follows chip select at the release
      next_mode = i_cs_n ? cfg_loader_pkg::MODE_LATER : cfg_loader_pkg::MODE_FIRST;
    end
    if (!i_oe) begin
      // Enable low is the reset: counter, stream and clock all return home
      next_addr = '0;
      next_done = 1'b0;
      next_rd_addr = '0;
      next_loaded = 1'b0;
      next_bits_left = '0;
      next_div_cnt = '0;
      next_dclk_int = 1'b0;
    end else begin
      // Word prefetch from the store
      if (fifo_in_valid && fifo_in_ready) begin
        next_rd_addr = RD_W'(rd_addr + 1'b1);
      end
      // Bit address counter
      if (advance) begin
        if (addr == FINAL) begin
          next_done = 1'b1;
        end else begin
          next_addr = ADDR_W'(addr + 1'b1);
        end
      end
      // Serialiser: shift within a word, reload between words
      if (advance && !word_last) begin
        next_sh = {1'b0, sh[WORD_W-1:1]};
        next_bits_left = BL_W'(bits_left - 1'b1);
      end else if (!loaded || (advance && word_last)) begin
        if (fifo_out_valid) begin
          next_sh = fifo_out_data;
          next_bits_left = BL_W'(WORD_W);
          next_loaded = 1'b1;
        end else begin
          next_loaded = 1'b0;
        end
      end
      // Internal oscillator: divider of the core clock
      if (osc_run) begin
        if (div_cnt == HALF_LAST) begin
          next_div_cnt = '0;
          next_dclk_int = !dclk_int;
        end else begin
          next_div_cnt = DIV_W'(div_cnt + 1'b1);
        end
      end else begin
        next_div_cnt = '0;
        next_dclk_int = 1'b0;
      end
    end
    // Data drives only while enabled, selected and not finished
    next_data_oe = i_oe && !i_cs_n && !next_done;
    next_casc_n = (next_addr != FINAL);
  end

  // Register stage; every output is a flip-flop
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      mode <= cfg_loader_pkg::MODE_LATER;
      oe_prev <= cfg_loader_pkg::OE_PREV_RST;
      addr <= '0;
      done <= 1'b0;
      rd_addr <= '0;
      sh <= '0;
      bits_left <= '0;
      loaded <= 1'b0;
      div_cnt <= '0;
      dclk_int <= cfg_loader_pkg::DCLK_RST;
      dclk_prev <= 1'b0;
      o_dclk <= cfg_loader_pkg::DCLK_RST;
      o_dclk_oe <= 1'b0;
      o_target_serial_data_in <= 1'b0;
      o_target_serial_data_oe <= cfg_loader_pkg::DATA_OE_RST;
      o_cascade_select_out_n <= cfg_loader_pkg::CASC_N_RST;
    end else begin
      mode <= next_mode;
      oe_prev <= i_oe;
      addr <= next_addr;
      done <= next_done;
      rd_addr <= next_rd_addr;
      sh <= next_sh;
      bits_left <= next_bits_left;
      loaded <= next_loaded;
      div_cnt <= next_div_cnt;
      dclk_int <= next_dclk_int;
      dclk_prev <= i_dclk;
      o_dclk <= next_dclk_int;
      o_dclk_oe <= (next_mode == cfg_loader_pkg::MODE_FIRST);
      o_target_serial_data_in <= next_sh[0];
      o_target_serial_data_oe <= next_data_oe;
      o_cascade_select_out_n <= next_casc_n;
    end
  end

  // Checks on the serial link behaviour; all share the core clock and the block reset
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_srst);

  // Enable released after being low
  sequence oe_release_s;
    !i_oe ##1 i_oe;
  endsequence

  // A pending transfer seen for one cycle
  sequence pending_s;
    i_oe && !i_cs_n && !done;
  endsequence

  // Serial clock just went high with the oscillator still allowed to run
  sequence osc_high_s;
    $rose(o_dclk) && osc_run;
  endsequence

  // Serial clock just went low with the oscillator still allowed to run
  sequence osc_low_s;
    $fell(o_dclk) && osc_run;
  endsequence

  // Clock source must park its clock low whenever it may not run
  clk_idle_a: assert property (!i_oe |=> !o_dclk)
    else $error("serial clock not low with enable low");
  clk_done_a: assert property (done |=> !o_dclk)
    else $error("serial clock not low after finish");
  // A later member never makes a clock of its own, so two drivers never fight on the pin
  clk_later_a: assert property (mode == cfg_loader_pkg::MODE_LATER |=> !o_dclk)
    else $error("later member clocked");

  // Counter behaviour: cleared by the enable pin, steps only on a granted edge
  addr_clear_a: assert property (!i_oe |=> addr == '0 && !done)
    else $error("counter not cleared");
  count_hold_a: assert property (i_oe && !advance |=> $stable(addr))
    else $error("counter moved without edge");
  count_step_a: assert property (advance && addr != FINAL |=> addr == $past(addr) + 1'b1)
    else $error("counter did not step");
  // Chip select high blocks counting even with serial clock edges present
  count_desel_a: assert property (i_oe && i_cs_n |=> $stable(addr))
    else $error("counter moved while deselected");
  // Once finished the counter and the flag stay put until the enable pin drops
  count_done_a: assert property (done && i_oe |=> done && $stable(addr))
    else $error("finish state lost");

  // Data pin driver and the bit on it
  data_release_a: assert property (done |=> !o_target_serial_data_oe)
    else $error("data driven after finish");
  data_desel_a: assert property (i_cs_n |=> !o_target_serial_data_oe)
    else $error("data driven deselected");
  data_drive_a: assert property (pending_s ##1 (i_oe && !i_cs_n && !done) |-> o_target_serial_data_oe)
    else $error("data not driven");
  // A bit must stand until the next granted edge, or the target samples a moving value
  data_hold_a: assert property (i_oe && loaded && !advance |=> $stable(o_target_serial_data_in))
    else $error("data bit moved without edge");

  // Cascade output follows the counter's final position
  casc_final_a: assert property (addr == FINAL && i_oe |=> !o_cascade_select_out_n)
    else $error("cascade not low at end");
  // Enable low returns the cascade output high so the next member waits again
  casc_clear_a: assert property (!i_oe && FINAL != '0 |=> o_cascade_select_out_n)
    else $error("cascade not cleared");

  // Chain position taken at the enable release
  mode_first_a: assert property (oe_release_s ##0 !i_cs_n |=> o_dclk_oe)
    else $error("not first member");
  mode_later_a: assert property (oe_release_s ##0 i_cs_n |=> !o_dclk_oe)
    else $error("not later member");

  // Oscillator gating and phase lengths; the counts of two match the package half period
  osc_gate_a: assert property ($rose(dclk_int) |-> $past(i_oe && !i_cs_n && !done))
    else $error("oscillator ran idle");
  osc_period_a: assert property (osc_high_s |-> o_dclk [*2])
    else $error("serial clock high phase short");
  osc_low_a: assert property (osc_low_s |-> !o_dclk [*2])
    else $error("serial clock low phase short");

endmodule

/* File: hdl/cfg_loader_pkg.sv */
// Shared constants and types for the serial configuration bitstream source
package cfg_loader_pkg;

  // Core clock period in nanoseconds (40 MHz)
  localparam int CLK_PERIOD_NS = 25;

  // Internal oscillator half period in nanoseconds
  localparam int OSC_HALF_NS = 50;

  // Half period in core cycles, rounded up so the serial clock never runs faster than intended
  localparam int OSC_HALF_CYC_RAW = (OSC_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OSC_HALF_CYC = (OSC_HALF_CYC_RAW < 1) ? 1 : OSC_HALF_CYC_RAW;

  // Default stored bitstream length in bits
  localparam int BIT_COUNT_DEF = 1024;

  // Default width of one stored word
  localparam int WORD_W_DEF = 8;

  // Default depth of the prefetch buffer
  localparam int FIFO_DEPTH_DEF = 16;

  // Values after reset
  localparam logic CASC_N_RST = 1'b1;
  localparam logic DCLK_RST = 1'b0;
  localparam logic DATA_OE_RST = 1'b0;
  localparam logic OE_PREV_RST = 1'b0;

  // Chain position decided when the output-enable pin is released
  typedef enum logic {
    MODE_LATER = 1'b0,
    MODE_FIRST = 1'b1
  } mode_e;

endpackage

/* File: hdl/cfg_stream_fifo.sv */
// Synchronous word FIFO with valid/ready on both sides and a flush input
`timescale 1ns/1ps
module cfg_stream_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic i_core_clk,
  input wire logic i_srst,
  input wire logic i_flush,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);

  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CNT_W = $clog2(DEPTH + 1);

  // Storage and pointers
  logic [WIDTH-1:0] store [DEPTH];
  logic [PTR_W-1:0] wr_ptr;
  logic [PTR_W-1:0] rd_ptr;
  logic [CNT_W-1:0] count;
  logic [PTR_W-1:0] next_wr_ptr;
  logic [PTR_W-1:0] next_rd_ptr;
  logic [CNT_W-1:0] next_count;
  logic push;
  logic pop;

  // Full and empty come straight from the occupancy count
  assign o_in_ready = (count != CNT_W'(DEPTH));
  assign o_out_valid = (count != '0);
  assign o_out_data = store[rd_ptr];

  // Pointer and count update
  always_comb begin
    push = i_in_valid && o_in_ready;
    pop = o_out_valid && i_out_ready;
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count = count;
    if (i_flush) begin
      // Flush drops everything, including a push in the same cycle
      next_wr_ptr = '0;
      next_rd_ptr = '0;
      next_count = '0;
    end else begin
      if (push) begin
        next_wr_ptr = (wr_ptr == PTR_W'(DEPTH - 1)) ? '0 : PTR_W'(wr_ptr + 1'b1);
      end
      if (pop) begin
        next_rd_ptr = (rd_ptr == PTR_W'(DEPTH - 1)) ? '0 : PTR_W'(rd_ptr + 1'b1);
      end
      if (push && !pop) begin
        next_count = CNT_W'(count + 1'b1);
      end else if (pop && !push) begin
        next_count = CNT_W'(count - 1'b1);
      end
    end
  end

  // Register stage
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
  end

  // Data array carries no reset
  always_ff @(posedge i_core_clk) begin
    if (push && !i_flush) begin
      store[wr_ptr] <= i_in_data;
    end
  end

endmodule

/* File: test/cfg_target_port_model.sv */
// Model of the target device's serial configuration input
`timescale 1ns/1ps
module cfg_target_port_model (
  input wire logic i_core_clk,
  input wire logic i_clear,
  input wire logic i_dclk_pin,
  input wire logic i_data_drv,
  input wire logic i_data_oe,
  output logic o_data_pin,
  output logic [63:0] o_cap_bits,
  output logic [15:0] o_cap_cnt
);
  logic prev_clk = 1'b0; // Clock pin one cycle ago
  logic prev_data = 1'b0; // Data pin one cycle ago
  logic last_drv = 1'b0; // Last value driven on data

  // A released pin shows the inverse of its last value, so a stale bit never passes as good
  assign o_data_pin = i_data_oe ? i_data_drv : ~last_drv;

  // Take on each clock rise the bit that stood before the rise, as a real input latch does
  always @(posedge i_core_clk) begin
    if (i_data_oe) begin
      last_drv <= i_data_drv;
    end
    prev_clk <= i_dclk_pin;
    prev_data <= o_data_pin;
    if (i_clear) begin
      o_cap_cnt <= 16'h0000;
      o_cap_bits <= '0;
    end else if (i_dclk_pin && !prev_clk && o_cap_cnt < 16'h0040) begin
      o_cap_bits[o_cap_cnt[5:0]] <= prev_data;
      o_cap_cnt <= o_cap_cnt + 16'h0001;
    end
  end
endmodule

/* File: test/test_serial_config_bitstream_source.sv */
// Self-checking bench for the serial configuration bitstream source
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin err_total++; \
  $display("[ERR] %s expected %0h seen %0h", nm, e, g); end end
module test_serial_config_bitstream_source;
  localparam int BITS = 32; // Short stream keeps the run brief
  localparam int WW = 8;
  localparam int WORDS = 4;
  logic i_core_clk = 1'b0;
  logic i_srst = 1'b1;
  logic i_oe = 1'b0;
  logic i_cs_n = 1'b0;
  logic tb_dclk = 1'b0; // Upstream chain clock, used in later mode
  logic i_prog_wr = 1'b0;
  logic [1:0] i_prog_addr = 2'h0;
  logic [7:0] i_prog_data = 8'h00;
  logic cap_clr = 1'b1;
  logic o_dclk, o_dclk_oe, data_drv, data_oe, casc_n, data_pin;
  logic [63:0] cap_bits;
  logic [15:0] cap_cnt;
  wire dclk_pin = o_dclk_oe ? o_dclk : tb_dclk; // Resolved serial clock pin
  int err_total = 0;
  int checks_done = 0;
  int seed = 24428;
  logic [7:0] mem [WORDS]; // Reference copy of the store

  // 40 MHz core clock
  always #12.5 i_core_clk = ~i_core_clk;

  serial_config_bitstream_source #(.BIT_COUNT(BITS), .WORD_W(WW), .FIFO_DEPTH(16)) dut (
    .i_core_clk(i_core_clk), .i_srst(i_srst), .i_oe(i_oe), .i_cs_n(i_cs_n), .i_dclk(dclk_pin),
    .o_dclk(o_dclk), .o_dclk_oe(o_dclk_oe), .o_target_serial_data_in(data_drv),
    .o_target_serial_data_oe(data_oe), .o_cascade_select_out_n(casc_n),
    .i_prog_wr(i_prog_wr), .i_prog_addr(i_prog_addr), .i_prog_data(i_prog_data));

  cfg_target_port_model part (
    .i_core_clk(i_core_clk), .i_clear(cap_clr), .i_dclk_pin(dclk_pin), .i_data_drv(data_drv),
    .i_data_oe(data_oe), .o_data_pin(data_pin), .o_cap_bits(cap_bits), .o_cap_cnt(cap_cnt));

  // Closing report and verdict
  task automatic end_sim();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Step n edges, then 1 ns so inputs change off the edge
  task automatic cyc(input int n);
    repeat (n) @(posedge i_core_clk);
    #1;
  endtask

  // Bounded wait: sel 0 for cascade low, sel 1 for data release
  task automatic wait_for(input int sel);
    int k;
    k = 0;
    while ((sel == 0 ? casc_n !== 1'b0 : data_oe !== 1'b0) && k < 600) begin
      cyc(1);
      k++;
    end
    if (k >= 600) begin
      err_total++;
      $display("[ERR] wait %0d expected 1 seen 0", sel);
      end_sim();
    end
  endtask

  // Fill the store with random words, one write pulse each
  task automatic program_store();
    for (int w = 0; w < WORDS; w++) begin
      mem[w] = 8'($random(seed));
      i_prog_addr = 2'(w);
      i_prog_data = mem[w];
      i_prog_wr = 1'b1;
      cyc(1);
      i_prog_wr = 1'b0;
      cyc(1);
    end
  endtask

  // Expected stream: word 0 upward, low bit first
  function automatic logic [BITS-1:0] exp_bits();
    logic [BITS-1:0] v;
    for (int i = 0; i < BITS; i++) v[i] = mem[i / WW][i % WW];
    return v;
  endfunction

  // Reset pulse on the enable pin with the chosen select level, then release
  task automatic start(input logic cs);
    i_cs_n = cs;
    i_oe = 1'b0;
    cap_clr = 1'b1;
    cyc(2);
    cap_clr = 1'b0;
    i_oe = 1'b1;
    cyc(2);
  endtask

  // Upstream member clocking us; slow edges, 3 cycles per level
  task automatic pulses(input int n);
    repeat (n) begin
      tb_dclk = 1'b1;
      cyc(3);
      tb_dclk = 1'b0;
      cyc(3);
    end
  endtask

  // Whole stream as first member, then the idle clock afterwards
  task automatic first_run();
    start(1'b0);
    `CHK("dclk_oe", 1'b1, o_dclk_oe);
    `CHK("data_oe", 1'b1, data_oe);
    wait_for(0);
    cyc(1); // Target counts a clock rise one core edge after the pin moves
    `CHK("bits at cascade", 16'(BITS - 1), cap_cnt);
    wait_for(1);
    cyc(1);
    `CHK("bit count", 16'(BITS), cap_cnt);
    `CHK("stream", exp_bits(), cap_bits[BITS-1:0]);
    repeat (8) begin
      cyc(1);
      `CHK("dclk idle", 1'b0, o_dclk);
      `CHK("cascade held", 1'b0, casc_n);
    end
  endtask

  // Bound on the whole run
  initial begin
    repeat (20000) @(posedge i_core_clk);
    err_total++;
    $display("[ERR] run length expected 0 seen 1");
    end_sim();
  end

  initial begin
    cyc(8);
    i_srst = 1'b0;
    cyc(1);
    `CHK("dclk_oe reset", 1'b0, o_dclk_oe);
    program_store();
    first_run();
    // Abort mid-stream: clock stops, data released, cascade back high
    start(1'b0);
    cyc(40);
    i_oe = 1'b0;
    cyc(2);
    `CHK("dclk abort", 1'b0, o_dclk);
    `CHK("data_oe abort", 1'b0, data_oe);
    `CHK("cascade abort", 1'b1, casc_n);
    // Restart must send from bit 0 again
    first_run();
    program_store();
    // Later member: deselected edges must not count
    start(1'b1);
    `CHK("dclk_oe later", 1'b0, o_dclk_oe);
    `CHK("data_oe desel", 1'b0, data_oe);
    pulses(5);
    `CHK("data_oe desel", 1'b0, data_oe);
    `CHK("cascade desel", 1'b1, casc_n);
    i_cs_n = 1'b0;
    cap_clr = 1'b1;
    cyc(6);
    cap_clr = 1'b0;
    `CHK("data_oe sel", 1'b1, data_oe);
    pulses(BITS);
    cyc(2);
    `CHK("later stream", exp_bits(), cap_bits[BITS-1:0]);
    `CHK("later release", 1'b0, data_oe);
    pulses(3);
    `CHK("later done", 1'b0, data_oe);
    `CHK("later cascade", 1'b0, casc_n);
    end_sim();
  end
endmodule
